// ==== spwp_pkg.sv ====
// Shared constants for the serdes parallel word port
package spwp_pkg;
   localparam int          WORD_W        = 20;
   localparam int          SYM_W         = 10;
   localparam int          BYTE_W        = 8;
   localparam int          SYNC_W        = 22;
   localparam int          CNT_W         = 5;
   localparam logic [4:0]  FULL_BITS     = 5'h14;
   localparam logic [4:0]  HALF_BITS     = 5'h0a;
   localparam int          TXC_MIN_MHZ   = 100;
   localparam int          TXC_MAX_MHZ   = 130;
   // Register byte offsets
   localparam logic [3:0]  OFS_CTRL      = 4'h0;
   localparam logic [3:0]  OFS_STATUS    = 4'h4;
   localparam logic [3:0]  OFS_TXCNT     = 4'h8;
   // Control fields
   localparam int          CTRL_TX_FULL  = 0;
   localparam int          CTRL_RX_FULL  = 1;
   localparam int          CTRL_CODE_EN  = 2;
   localparam logic [2:0]  CTRL_RESET    = 3'h3;
   localparam int          STAT_CODE_ERR = 0;
   localparam int          KLO_BIT       = 16;
   localparam int          KHI_BIT       = 17;
   localparam int          SYNC_TXCLK    = 21;
   localparam int          SYNC_RXSER    = 0;
endpackage : spwp_pkg

// ==== spwp_proto_dev.sv ====
// Protocol device model driving the transmit word bus
`timescale 1ns/1ps
`default_nettype none
module spwp_proto_dev
   import spwp_pkg::*;
(
   input  wire logic [spwp_pkg::WORD_W-1:0] word_i,
   output logic                             tx_word_clk_o,
   output logic      [spwp_pkg::WORD_W-1:0] tx_data_o
);
   // Scaled continuous word clock, exactly a sixteenth of the sampling clock
   initial
   begin
      tx_word_clk_o = 1'b0;
      tx_data_o     = '0;
      forever
      begin
         #400 tx_word_clk_o = 1'b1;
         #400 tx_word_clk_o = 1'b0;
         tx_data_o = word_i;
      end
   end
endmodule : spwp_proto_dev
`default_nettype wire

// ==== spwp_word_port.sv ====
// Parallel word port of a serializer/deserializer with Wishbone control
//
// What this block does
// - Register transmit bus on each word clock rise
// - Full rate: capture all bits, serialize all but 18-19 when coded
// - Half rate: serialize lower half only
// - Bypass: twenty raw bits, half rate ten
// - Coded: bytes 0-7, 8-15, K at 16, 17
// - Coded: both bytes full, low byte half
// - Low byte first, LSB first
// - Receive data on word clock, hi-Z in reset
// - Full rate full width, half rate lower half
// - Bypass: raw bits 0-19, half 0-9
// - Decoded bytes with K status, 18-19 hi-Z
// - Decoded: both bytes full, low byte half
// - First byte low, first bit LSB
// - Word clock is bit clock over 20 or 10
// - Transmit select high: twenty times, two bytes
// - Transmit select low: ten times, one byte
// - Receive select high: twenty times, two bytes
//
// The Wishbone interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module spwp_word_port
   import spwp_pkg::*;
(
   input  wire logic                        clk_sys_i,
   input  wire logic                        srst_i,
   input  wire logic                        wb_cyc_i,
   input  wire logic                        wb_stb_i,
   input  wire logic                        wb_we_i,
   input  wire logic [3:0]                  wb_adr_i,
   input  wire logic [3:0]                  wb_sel_i,
   input  wire logic [31:0]                 wb_dat_i,
   output logic      [31:0]                 wb_dat_o,
   output logic                             wb_ack_o,
   input  wire logic                        tx_word_clk_i,
   input  wire logic [spwp_pkg::WORD_W-1:0] tx_data_i,
   output logic                             tx_serial_o,
   output logic                             tx_serial_oe_o,
   input  wire logic                        rx_serial_i,
   output logic      [spwp_pkg::WORD_W-1:0] rx_data_o,
   output logic      [spwp_pkg::WORD_W-1:0] rx_data_oe_o,
   output logic                             rx_word_clk_o
);
   import spwp_pkg::*;

   // Stand-in code group: byte, K flag and an even-parity bit; the real code tables are outside this block
   function automatic logic [SYM_W-1:0] enc_sym(input logic [BYTE_W-1:0] b, input logic k);
      enc_sym = {^{k, b}, k, b};
   endfunction : enc_sym

   // Pin synchronisers
   logic [SYNC_W-1:0]  s1_r, s2_r, s3_r, filt_r;
   logic [SYNC_W-1:0]  s1_nxt, s2_nxt, s3_nxt, filt_nxt;
   logic               txc_prev_r, txc_prev_nxt;
   logic               txc_rise;

   always_comb
   begin
      s1_nxt       = {tx_word_clk_i, tx_data_i, rx_serial_i};
      s2_nxt       = s1_r;
      s3_nxt       = s2_r;
      txc_prev_nxt = filt_r[SYNC_TXCLK];
      txc_rise     = filt_r[SYNC_TXCLK] & ~txc_prev_r;
   end

   // A level counts only once the second and third stages agree;
   // a one-cycle glitch on a pin therefore never reaches the logic
   for (genvar g = 0; g < SYNC_W; g++)
   begin : g_filt
      assign filt_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : filt_r[g];
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         s1_r       <= '0;
         s2_r       <= '0;
         s3_r       <= '0;
         filt_r     <= '0;
         txc_prev_r <= 1'b0;
      end
      else
      begin
         s1_r       <= s1_nxt;
         s2_r       <= s2_nxt;
         s3_r       <= s3_nxt;
         filt_r     <= filt_nxt;
         txc_prev_r <= txc_prev_nxt;
      end
   end

   // Register file
   logic [2:0]   ctrl_r, ctrl_nxt;
   logic         code_err_r, code_err_nxt;
   logic [15:0]  txcnt_r, txcnt_nxt;
   logic [31:0]  dat_nxt;
   logic         ack_nxt;
   logic         wb_req, wb_wr;
   logic         code_err_set;
   logic         tx_full, rx_full, code_en;

   assign tx_full = ctrl_r[CTRL_TX_FULL];
   assign rx_full = ctrl_r[CTRL_RX_FULL];
   assign code_en = ctrl_r[CTRL_CODE_EN];

   always_comb
   begin
      // Ack is registered: a request is taken once and answered one cycle later
      wb_req       = wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_wr        = wb_req & wb_we_i;
      ack_nxt      = wb_req;
      ctrl_nxt     = ctrl_r;
      code_err_nxt = code_err_r;
      // Free-running count of captured words; it wraps, so software takes differences
      txcnt_nxt    = txcnt_r + (txc_rise ? 16'h0001 : 16'h0000);
      dat_nxt      = wb_dat_o;
      if (wb_wr && wb_sel_i[0] && wb_adr_i == OFS_CTRL)
      begin
         ctrl_nxt = wb_dat_i[2:0];
      end
      if (wb_wr && wb_sel_i[0] && wb_adr_i == OFS_STATUS && wb_dat_i[STAT_CODE_ERR])
      begin
         code_err_nxt = 1'b0;
      end
      // A new error in the clearing cycle is kept
      if (code_err_set)
      begin
         code_err_nxt = 1'b1;
      end
      if (wb_req && !wb_we_i)
      begin
         unique case (wb_adr_i)
            OFS_CTRL:   dat_nxt = {29'h0, ctrl_r};
            OFS_STATUS: dat_nxt = {31'h0, code_err_r};
            OFS_TXCNT:  dat_nxt = {16'h0, txcnt_r};
            default:    dat_nxt = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         ctrl_r     <= CTRL_RESET;
         code_err_r <= 1'b0;
         txcnt_r    <= 16'h0;
         wb_dat_o   <= 32'h0;
         wb_ack_o   <= 1'b0;
      end
      else
      begin
         ctrl_r     <= ctrl_nxt;
         code_err_r <= code_err_nxt;
         txcnt_r    <= txcnt_nxt;
         wb_dat_o   <= dat_nxt;
         wb_ack_o   <= ack_nxt;
      end
   end

   // Transmit path: one serial bit per system clock
   logic [WORD_W-1:0]  tx_hold_r, tx_hold_nxt;
   logic [WORD_W-1:0]  tx_sh_r, tx_sh_nxt;
   logic [CNT_W-1:0]   tx_cnt_r, tx_cnt_nxt;
   logic               tx_oe_nxt;
   logic [WORD_W-1:0]  tx_word;
   logic [CNT_W-1:0]   tx_len;

   always_comb
   begin
      tx_hold_nxt = txc_rise ? filt_r[WORD_W:1] : tx_hold_r;
      tx_len      = tx_full ? FULL_BITS : HALF_BITS;
      // Unused upper half sends nothing; of its inputs only K at bit 16 is looked at, in coded mode
      // Bits 18 and 19 never reach the encoder
      if (code_en && tx_full)
      begin
         tx_word = {enc_sym(tx_hold_r[15:8], tx_hold_r[KHI_BIT]),
                    enc_sym(tx_hold_r[7:0], tx_hold_r[KLO_BIT])};
      end
      else if (code_en)
      begin
         tx_word = {10'h0, enc_sym(tx_hold_r[7:0], tx_hold_r[KLO_BIT])};
      end
      else if (tx_full)
      begin
         tx_word = tx_hold_r;
      end
      else
      begin
         tx_word = {10'h0, tx_hold_r[9:0]};
      end
      tx_oe_nxt = 1'b1;
      if (tx_cnt_r == tx_len - 5'h01)
      begin
         tx_cnt_nxt = 5'h00;
         tx_sh_nxt  = tx_word;
      end
      else
      begin
         tx_cnt_nxt = tx_cnt_r + 5'h01;
         // Zeros fill from the top; only tx_len bits leave per word
         tx_sh_nxt  = {1'b0, tx_sh_r[WORD_W-1:1]};
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         tx_hold_r      <= '0;
         tx_sh_r        <= '0;
         tx_cnt_r       <= 5'h00;
         tx_serial_oe_o <= 1'b0;
      end
      else
      begin
         tx_hold_r      <= tx_hold_nxt;
         tx_sh_r        <= tx_sh_nxt;
         tx_cnt_r       <= tx_cnt_nxt;
         tx_serial_oe_o <= tx_oe_nxt;
      end
   end

   assign tx_serial_o = tx_sh_r[0];

   // Receive path; word alignment is free running from reset, no comma search
   logic [WORD_W-1:0]  rx_sh_r, rx_sh_nxt;
   logic [CNT_W-1:0]   rx_cnt_r, rx_cnt_nxt;
   logic [WORD_W-1:0]  rx_dat_nxt, rx_oe_nxt;
   logic               rx_clk_nxt;
   logic [CNT_W-1:0]   rx_len;
   logic [WORD_W-1:0]  rx_word;
   logic               rx_bit;

   always_comb
   begin
      rx_bit       = filt_r[SYNC_RXSER];
      rx_len       = rx_full ? FULL_BITS : HALF_BITS;
      rx_sh_nxt    = {rx_bit, rx_sh_r[WORD_W-1:1]};
      // First bit ends in the lowest position of the word
      if (rx_full)
      begin
         rx_word = rx_sh_nxt;
      end
      else
      begin
         // Half rate: the last ten bits sit in the top of the shifter
         rx_word = {10'h0, rx_sh_nxt[WORD_W-1:SYM_W]};
      end
      rx_dat_nxt   = rx_data_o;
      code_err_set = 1'b0;
      rx_oe_nxt    = {WORD_W{1'b1}};
      if (code_en)
      begin
         rx_oe_nxt[19:18] = 2'h0;
      end
      if (rx_cnt_r == rx_len - 5'h01)
      begin
         rx_cnt_nxt = 5'h00;
         if (code_en)
         begin
            rx_dat_nxt   = {2'h0, rx_word[18], rx_word[8], rx_word[17:10], rx_word[7:0]};
            code_err_set = (^rx_word[9:0]) | (rx_full & (^rx_word[19:10]));
         end
         else
         begin
            rx_dat_nxt = rx_word;
         end
      end
      else
      begin
         rx_cnt_nxt = rx_cnt_r + 5'h01;
      end
      // Data moves on the falling half so it is steady at the rising edge
      rx_clk_nxt = rx_cnt_nxt >= (rx_len >> 1);
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         rx_sh_r       <= '0;
         rx_cnt_r      <= 5'h00;
         rx_data_o     <= '0;
         rx_data_oe_o  <= '0;
         rx_word_clk_o <= 1'b0;
      end
      else
      begin
         rx_sh_r       <= rx_sh_nxt;
         rx_cnt_r      <= rx_cnt_nxt;
         rx_data_o     <= rx_dat_nxt;
         rx_data_oe_o  <= rx_oe_nxt;
         rx_word_clk_o <= rx_clk_nxt;
      end
   end
endmodule : spwp_word_port
`default_nettype wire

// ==== spwp_word_port_properties.sv ====
// Pin-level assertions for the word port
`timescale 1ns/1ps
`default_nettype none
module spwp_chk
   import spwp_pkg::*;
(
   input wire logic                        clk_sys_i,
   input wire logic                        srst_i,
   input wire logic                        wb_cyc_i,
   input wire logic                        wb_stb_i,
   input wire logic                        wb_we_i,
   input wire logic [3:0]                  wb_adr_i,
   input wire logic [3:0]                  wb_sel_i,
   input wire logic [31:0]                 wb_dat_i,
   input wire logic                        wb_ack_o,
   input wire logic                        tx_serial_oe_o,
   input wire logic [spwp_pkg::WORD_W-1:0] rx_data_o,
   input wire logic [spwp_pkg::WORD_W-1:0] rx_data_oe_o,
   input wire logic                        rx_word_clk_o
);
   import spwp_pkg::*;
   logic [2:0] ctrl_r;
   logic [5:0] settle_r;
   logic [4:0] run_r;
   logic       wclk_r;
   logic       ok;
   logic       ctrl_wr;
   // Rate changes may corrupt a word, so checks other than reset, ack and serial enable wait until the setting has stood a while
   assign ok = settle_r == 6'h3f;
   assign ctrl_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] && wb_adr_i == OFS_CTRL;
   always_ff @(posedge clk_sys_i)
   begin
      wclk_r <= rx_word_clk_o;
      run_r  <= (rx_word_clk_o != wclk_r) ? 5'h01 : run_r + 5'h01;
      if (srst_i || ctrl_wr)
         settle_r <= 6'h00;
      else if (!ok)
         settle_r <= settle_r + 6'h01;
      if (srst_i)
         ctrl_r <= CTRL_RESET;
      else if (ctrl_wr)
         ctrl_r <= wb_dat_i[2:0];
   end
   chk_reset_quiet: assert property (@(posedge clk_sys_i) srst_i |=>
      rx_data_oe_o == '0 && !rx_word_clk_o) else $error("outputs active in reset");
   chk_ack_next: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack not one cycle after request");
   chk_txoe_on: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      !$past(srst_i) |-> tx_serial_oe_o) else $error("serial out not driven");
   chk_wclk_half: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      ok && rx_word_clk_o != wclk_r |-> run_r == (ctrl_r[CTRL_RX_FULL] ? 5'h0a : 5'h05))
      else $error("word clock phase length wrong");
   chk_data_fall: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      ok && !$stable(rx_data_o) |-> $fell(rx_word_clk_o)) else $error("rx data moved off word boundary");
   chk_code_hiz: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      ok && ctrl_r[CTRL_CODE_EN] |-> rx_data_oe_o[19:18] == 2'h0) else $error("bits 18-19 driven");
   chk_oe_full: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      ok |-> &rx_data_oe_o[17:0] && (ctrl_r[CTRL_CODE_EN] || &rx_data_oe_o[19:18]))
      else $error("rx bits not driven");
   chk_half_upper: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      ok && !ctrl_r[CTRL_RX_FULL] |-> (ctrl_r[CTRL_CODE_EN] ? {rx_data_o[17], rx_data_o[15:8]} == 9'h000
      : rx_data_o[19:10] == 10'h000)) else $error("upper half active at half rate");
endmodule : spwp_chk
bind spwp_word_port spwp_chk u_chk (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
   .tx_serial_oe_o(tx_serial_oe_o), .rx_data_o(rx_data_o), .rx_data_oe_o(rx_data_oe_o),
   .rx_word_clk_o(rx_word_clk_o));
`default_nettype wire

// ==== tb_spwp_word_port.sv ====
// Self-checking bench for the word port
`timescale 1ns/1ps
`default_nettype none
module tb_spwp_word_port;
   import spwp_pkg::*;
   logic        clk_sys_i, srst_i, wb_cyc_i, wb_stb_i, wb_we_i, rx_serial_i, tx_word_clk_i;
   logic        wb_ack_o, tx_serial_o, tx_serial_oe_o, rx_word_clk_o;
   logic [3:0]  wb_adr_i, wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd, rd0;
   logic [19:0] tx_data_i, rx_data_o, rx_data_oe_o, word, rx_pat, exp, mask;
   logic [39:0] cap;
   logic [2:0]  cfg;
   int          errors, checks_done;
   int          rx_idx = 0;
   spwp_word_port u_dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .tx_word_clk_i(tx_word_clk_i), .tx_data_i(tx_data_i), .tx_serial_o(tx_serial_o),
      .tx_serial_oe_o(tx_serial_oe_o), .rx_serial_i(rx_serial_i), .rx_data_o(rx_data_o),
      .rx_data_oe_o(rx_data_oe_o), .rx_word_clk_o(rx_word_clk_o));
   spwp_proto_dev u_proto (.word_i(word), .tx_word_clk_o(tx_word_clk_i), .tx_data_o(tx_data_i));
   initial
   begin
      clk_sys_i = 1'b0;
      forever #25 clk_sys_i = ~clk_sys_i;
   end
   // Periodic serial stream, twenty bits long
   always @(posedge clk_sys_i)
   begin
      rx_serial_i <= rx_pat[rx_idx];
      rx_idx <= (rx_idx == 19) ? 0 : rx_idx + 1;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checks_done++;
      if (seen !== want)
         $display("[ERR] %0t seen %h expected %h", $time, seen, want);
      if (seen !== want)
         errors++;
   endtask : check
   task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do @(posedge clk_sys_i); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : wb
   // True when the first-sent bits hold p, bit 0 first, at some offset
   function automatic logic has_win(input logic [39:0] c, input logic [19:0] p, input int n);
      logic [39:0] m;
      m = (40'h1 << n) - 40'h1;
      has_win = 1'b0;
      for (int k = 0; k < 20; k++)
         if (((c >> k) & m) === ({20'h0, p} & m))
            has_win = 1'b1;
   endfunction : has_win
   task automatic results;
      if (errors == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : results
   initial
   begin
      repeat (6000) @(posedge clk_sys_i);
      errors++;
      results();
   end
   initial
   begin
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
      {rx_pat, word, errors, checks_done} = '0;
      wb_sel_i = 4'hf;
      srst_i = 1'b1;
      repeat (3) @(posedge clk_sys_i);
      check({12'h0, rx_data_oe_o}, 32'h0);
      check({31'h0, rx_word_clk_o}, 32'h0);
      srst_i <= 1'b0;
      wb(1'b0, OFS_CTRL, 32'h0);
      check(rd, {29'h0, CTRL_RESET});
      check({31'h0, tx_serial_oe_o}, 32'h1);
      wb(1'b1, 4'hc, 32'hffffffff);
      wb(1'b0, 4'hc, 32'h0);
      check(rd, 32'h0);
      rx_pat <= 20'hfffff;
      word <= 20'hd3a61;
      for (int i = 0; i < 4; i++)
      begin
         cfg = 3'(12'h9c3 >> (3 * i));
         wb(1'b1, OFS_CTRL, {29'h0, cfg});
         repeat (120) @(posedge clk_sys_i);
         for (int b = 0; b < 40; b++)
         begin
            @(posedge clk_sys_i);
            cap[b] = tx_serial_o;
         end
         exp = cfg[CTRL_CODE_EN] ? {^{word[17], word[15:8]}, word[17], word[15:8],
                                    ^{word[16], word[7:0]}, word[16], word[7:0]} : word;
         check({31'h0, has_win(cap, exp, cfg[CTRL_TX_FULL] ? 20 : 10)}, 32'h1);
         mask = cfg[CTRL_CODE_EN] ? 20'h3ffff : 20'hfffff;
         exp = cfg[CTRL_CODE_EN] ? (cfg[CTRL_RX_FULL] ? 20'h3ffff : 20'h100ff)
                                 : (cfg[CTRL_RX_FULL] ? 20'hfffff : 20'h003ff);
         check({12'h0, rx_data_o & mask}, {12'h0, exp});
      end
      // Odd count of ones in every ten-bit alignment, runs long enough to pass the input filter
      rx_pat <= 20'h01c07;
      repeat (100) @(posedge clk_sys_i);
      wb(1'b0, OFS_STATUS, 32'h0);
      check({31'h0, rd[STAT_CODE_ERR]}, 32'h1);
      rx_pat <= 20'hfffff;
      repeat (60) @(posedge clk_sys_i);
      wb(1'b1, OFS_STATUS, 32'h1);
      wb(1'b0, OFS_STATUS, 32'h0);
      check({31'h0, rd[STAT_CODE_ERR]}, 32'h0);
      // Ten word clock periods of 16 system clocks lie between the two taking edges
      wb(1'b0, OFS_TXCNT, 32'h0);
      rd0 = rd;
      repeat (157) @(posedge clk_sys_i);
      wb(1'b0, OFS_TXCNT, 32'h0);
      check(rd - rd0, 32'h0000000a);
      results();
   end
endmodule : tb_spwp_word_port
`default_nettype wire
